// ==== logic/epv_port.v ====
// Purpose: eprom program and verify port
// Assumes: pins asynchronous, mclk 250 MHz
// Notes: array erased to ones after reset
`include "epv_defines.vh"
`default_nettype none
module epv_port #(
  parameter AW = 13,
  parameter [7:0] SIG_BYTE0 = 8'hA5, // arbitrary value
  parameter [7:0] SIG_BYTE1 = 8'h5A, // arbitrary value
  parameter PULSE_MIN_CYC = (`EPV_PULSE_MIN_NS * `EPV_MCLK_MHZ + 999) / 1000
) (
  input wire mclk, // clock
  input wire reset, // sync reset, high
  input wire reset_pin, // device reset pin
  input wire program_store_enable_n, // mode pin
  input wire latch_program_strobe, // program strobe
  input wire external_access_prog_supply, // ea high level
  input wire prog_supply_ok, // supply at program level
  input wire [7:0] port1_in, // address low
  input wire [7:0] port2_in, // address high, mode
  input wire [7:0] port3_in, // mode bits 7:6
  input wire [7:0] port0_in, // code byte in
  output reg [7:0] port0_out, // verify byte out
  output reg port0_oe, // high while driving port 0
  input wire [3:0] bus_addr, // register address
  input wire [7:0] bus_wdata, // write data
  input wire bus_wr, // write strobe
  input wire bus_rd, // read strobe
  output reg [7:0] bus_rdata // read data, next cycle
);
  // ************************************
  // functions
  // ************************************
  // decode mode from synced pin levels
  function [2:0] mode_of;
    input rst;
    input store_en_n;
    input strb;
    input ext_acc;
    input supply_on;
    input [1:0] p2m;
    input [1:0] p3m;
    begin
      mode_of = `EPV_MODE_NONE;
      if (rst && !store_en_n) begin
        if (supply_on) begin
          if (p2m == 2'h2 && p3m == 2'h3) begin
            mode_of = `EPV_MODE_PCODE;
          end else if (p2m == 2'h2 && p3m == 2'h2) begin
            mode_of = `EPV_MODE_PENC;
          end else if (p2m == 2'h3 && p3m == 2'h3) begin
            mode_of = `EPV_MODE_LOCK1;
          end else if (p2m == 2'h3 && p3m == 2'h0) begin
            mode_of = `EPV_MODE_LOCK2;
          end
        end else if (strb && ext_acc && p2m == 2'h0) begin
          if (p3m == 2'h3) begin
            mode_of = `EPV_MODE_VFY;
          end else if (p3m == 2'h0) begin
            mode_of = `EPV_MODE_SIG;
          end
        end
      end
    end
  endfunction
  // true for modes that pulse the strobe
  function is_prog;
    input [2:0] m;
    begin
      is_prog = (m == `EPV_MODE_PCODE) || (m == `EPV_MODE_PENC) ||
                (m == `EPV_MODE_LOCK1) || (m == `EPV_MODE_LOCK2);
    end
  endfunction
  // ************************************
  // pin synchronisers
  // ************************************
  wire [7:0] p1_s; // address low
  wire [7:0] p2_s; // address high and mode
  wire [7:0] p3_s; // mode bits
  wire [7:0] p0_s; // code byte
  wire [4:0] ctl_s; // control pins
  // every pin passes two flops first
  epv_sync #(.WIDTH(32)) u_sync_ports (
    .mclk(mclk),
    .reset(reset),
    .din({port1_in, port2_in, port3_in, port0_in}),
    .dout({p1_s, p2_s, p3_s, p0_s})
  );
  epv_sync #(.WIDTH(5)) u_sync_ctl (
    .mclk(mclk),
    .reset(reset),
    .din({reset_pin, program_store_enable_n, latch_program_strobe,
          external_access_prog_supply, prog_supply_ok}),
    .dout(ctl_s)
  );
  wire strobe_s = ctl_s[2]; // synced strobe
  // ************************************
  // mode and address
  // ************************************
  wire [AW-1:0] addr_w = {p2_s[AW-9:0], p1_s};
  wire [2:0] mode_w = mode_of(ctl_s[4], ctl_s[3], strobe_s, ctl_s[1], ctl_s[0],
                              p2_s[7:6], p3_s[7:6]);
  reg [AW-1:0] addr_reg; // last sampled address
  reg [7:0] data_reg; // last sampled code byte
  reg [2:0] mode_reg; // last decoded mode
  reg [7:0] settle_reg; // cycles of stable inputs
  wire changed_w = (addr_w != addr_reg) || (mode_w != mode_reg) ||
                   (is_prog(mode_w) && p0_s != data_reg);
  wire settled_w = (settle_reg >= `EPV_SETTLE_CYC);
  // track how long address, data and mode stood still
  always @(posedge mclk) begin
    if (reset) begin
      addr_reg <= {AW{1'b0}};
      data_reg <= 8'h00;
      mode_reg <= `EPV_MODE_NONE;
      settle_reg <= 8'h00;
    end else begin
      addr_reg <= addr_w;
      mode_reg <= mode_w;
      // in verify port 0 is ours, so data is held only when programming
      if (is_prog(mode_w)) begin
        data_reg <= p0_s;
      end
      if (changed_w) begin
        settle_reg <= 8'h00;
      end else if (!settled_w) begin
        settle_reg <= settle_reg + 8'h01;
      end
    end
  end
  // ************************************
  // strobe pulse counting
  // ************************************
  wire pulse_w; // good strobe pulse ended
  epv_strobe_meter #(.CW(16), .MIN_CYC(PULSE_MIN_CYC)) u_meter (
    .mclk(mclk),
    .reset(reset),
    .strobe(strobe_s),
    .pulse_ok(pulse_w)
  );
  reg [4:0] pcnt_reg; // pulses at this location
  reg [4:0] last_pcnt_reg; // pulses of the last sequence
  reg commit_reg; // one cycle, store the location
  // a sequence restarts whenever its location changes
  always @(posedge mclk) begin
    if (reset) begin
      pcnt_reg <= 5'h00;
      last_pcnt_reg <= 5'h00;
      commit_reg <= 1'b0;
    end else begin
      commit_reg <= 1'b0;
      if (changed_w || !is_prog(mode_w)) begin
        pcnt_reg <= 5'h00;
      end else if (pulse_w && pcnt_reg != 5'h1F) begin
        pcnt_reg <= pcnt_reg + 5'h01;
        last_pcnt_reg <= pcnt_reg + 5'h01;
        // store once the least sequence is reached; more pulses are harmless
        commit_reg <= (pcnt_reg + 5'h01 == `EPV_PULSES_MIN);
      end
    end
  end
  // ************************************
  // lock and encryption state
  // ************************************
  reg lock1_reg; // lock bit 1 programmed
  reg lock2_reg; // lock bit 2 programmed
  reg enc_set_reg; // some table byte programmed
  reg [7:0] enc_mem [0:31]; // encryption table
  reg busy_reg; // erase walk running
  reg [AW-1:0] erase_addr_reg; // erase walk address
  wire locked_w = lock1_reg || lock2_reg;
  wire do_code_w = commit_reg && mode_reg == `EPV_MODE_PCODE && !locked_w;
  wire do_enc_w = commit_reg && mode_reg == `EPV_MODE_PENC && !locked_w &&
                  addr_reg <= `EPV_ENC_LAST;
  wire erase_cmd_w = bus_wr && bus_addr == `EPV_REG_CTRL && bus_wdata[`EPV_CTRL_ERASE];
  // locks only ever set, short of an erase; a set in the erase cycle wins
  always @(posedge mclk) begin
    if (reset) begin
      lock1_reg <= 1'b0;
      lock2_reg <= 1'b0;
      enc_set_reg <= 1'b0;
    end else begin
      if (erase_cmd_w) begin
        lock1_reg <= 1'b0;
        lock2_reg <= 1'b0;
        enc_set_reg <= 1'b0;
      end
      if (commit_reg && !busy_reg) begin
        // the other lock stays writable after one is set
        if (mode_reg == `EPV_MODE_LOCK1) begin
          lock1_reg <= 1'b1;
        end
        if (mode_reg == `EPV_MODE_LOCK2) begin
          lock2_reg <= 1'b1;
        end
        if (do_enc_w) begin
          enc_set_reg <= 1'b1;
        end
      end
    end
  end
  // ************************************
  // array, erase walk and writes
  // ************************************
  reg [7:0] code_mem [0:(1<<AW)-1]; // code array
  reg [7:0] mem_q_reg; // read of addressed byte
  reg [7:0] enc_q_reg; // table byte for this address
  wire [AW-1:0] last_addr_w = {AW{1'b1}};
  // walk writes ones everywhere, one byte a cycle
  always @(posedge mclk) begin
    if (reset || erase_cmd_w) begin
      busy_reg <= 1'b1;
      erase_addr_reg <= {AW{1'b0}};
    end else if (busy_reg) begin
      if (erase_addr_reg == last_addr_w) begin
        busy_reg <= 1'b0;
      end
      erase_addr_reg <= erase_addr_reg + 1'b1;
    end
  end
  // programming can only clear bits, like a real cell
  always @(posedge mclk) begin
    if (busy_reg) begin
      code_mem[erase_addr_reg] <= `EPV_ERASED;
    end else if (do_code_w) begin
      code_mem[addr_reg] <= mem_q_reg & data_reg;
    end
    mem_q_reg <= code_mem[addr_w];
  end
  // table shares the erase walk over its 32 bytes
  always @(posedge mclk) begin
    if (busy_reg) begin
      enc_mem[erase_addr_reg[4:0]] <= `EPV_ERASED;
    end else if (do_enc_w) begin
      enc_mem[addr_reg[4:0]] <= enc_q_reg & data_reg;
    end
    enc_q_reg <= enc_mem[addr_w[4:0]];
  end
  // ************************************
  // verify output
  // ************************************
  reg [7:0] vfy_byte; // byte to show
  reg vfy_drive; // drive port 0
  // table bytes only ever mix into code data, never alone
  always @* begin
    vfy_byte = `EPV_ERASED;
    vfy_drive = 1'b0;
    if (settled_w && !busy_reg) begin
      if (mode_reg == `EPV_MODE_SIG) begin
        vfy_drive = 1'b1;
        if (addr_reg == `EPV_SIG_ADDR0) begin
          vfy_byte = SIG_BYTE0;
        end else if (addr_reg == `EPV_SIG_ADDR1) begin
          vfy_byte = SIG_BYTE1;
        end
      end else if (mode_reg == `EPV_MODE_VFY && !lock2_reg) begin
        vfy_drive = 1'b1;
        if (enc_set_reg) begin
          vfy_byte = ~(mem_q_reg ^ enc_q_reg);
        end else begin
          vfy_byte = mem_q_reg;
        end
      end
    end
  end
  // port 0 floats in every other mode; a few cycles settle, well under the limit
  always @(posedge mclk) begin
    if (reset) begin
      port0_out <= 8'h00;
      port0_oe <= 1'b0;
    end else begin
      port0_out <= vfy_byte;
      port0_oe <= vfy_drive;
    end
  end
  // ************************************
  // register port
  // ************************************
  // read data stands one cycle after the read strobe
  always @(posedge mclk) begin
    if (reset) begin
      bus_rdata <= 8'h00;
    end else if (bus_rd) begin
      if (bus_addr == `EPV_REG_STAT) begin
        bus_rdata <= {1'b0, mode_reg, busy_reg, enc_set_reg, lock2_reg, lock1_reg};
      end else if (bus_addr == `EPV_REG_PCNT) begin
        bus_rdata <= {3'h0, last_pcnt_reg};
      end else begin
        bus_rdata <= 8'h00; // ctrl and unmapped read zero
      end
    end else begin
      bus_rdata <= 8'h00;
    end
  end
endmodule // epv_port
`default_nettype wire

// ==== logic/epv_defines.vh ====
// Purpose: constants for the eprom program/verify port
// Assumes: mclk at 250 MHz
// Notes: included by epv_port only; the other epv design files do not include it
`ifndef EPV_DEFINES_VH
`define EPV_DEFINES_VH
// ************************************
// mode codes
// ************************************
`define EPV_MODE_NONE 3'h0
`define EPV_MODE_SIG 3'h1
`define EPV_MODE_VFY 3'h2
`define EPV_MODE_PCODE 3'h3
`define EPV_MODE_PENC 3'h4
`define EPV_MODE_LOCK1 3'h5
`define EPV_MODE_LOCK2 3'h6
// ************************************
// memory map of the array
// ************************************
`define EPV_ENC_LAST 13'h001F
`define EPV_SIG_ADDR0 13'h0030
`define EPV_SIG_ADDR1 13'h0031
`define EPV_ERASED 8'hFF
// ************************************
// register offsets and fields
// ************************************
`define EPV_REG_CTRL 4'h0
`define EPV_REG_STAT 4'h1
`define EPV_REG_PCNT 4'h2
`define EPV_CTRL_ERASE 0
`define EPV_ST_LOCK1 0
`define EPV_ST_LOCK2 1
`define EPV_ST_ENC 2
`define EPV_ST_BUSY 3
// ************************************
// timing
// ************************************
`define EPV_MCLK_MHZ 250
`define EPV_PULSES_MIN 5'h0F
`define EPV_PULSE_MIN_NS 90000
`define EPV_OSC_MAX_MHZ 6
`define EPV_OSC_PERIODS 48
`define EPV_SETTLE_CYC 8'h08
`endif

// ==== logic/epv_sync.v ====
// Purpose: two-flop synchroniser for pin levels
// Assumes: inputs are asynchronous to mclk
// Notes: first stage feeds only the second
`default_nettype none
module epv_sync #(
  parameter WIDTH = 8
) (
  input wire mclk, // clock
  input wire reset, // sync reset
  input wire [WIDTH-1:0] din, // pin levels
  output reg [WIDTH-1:0] dout // synced levels
);
  reg [WIDTH-1:0] meta_reg; // first stage
  // two stages, no logic between
  always @(posedge mclk) begin
    if (reset) begin
      meta_reg <= {WIDTH{1'b0}};
      dout <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule // epv_sync
`default_nettype wire

// ==== logic/epv_strobe_meter.v ====
// Purpose: measures program strobe low pulses
// Assumes: strobe already synchronised
// Notes: pulse counted at its rising edge
`default_nettype none
module epv_strobe_meter #(
  parameter CW = 16,
  parameter MIN_CYC = 22500
) (
  input wire mclk, // clock
  input wire reset, // sync reset
  input wire strobe, // synced strobe level
  output reg pulse_ok // one cycle, good pulse ended
);
  reg [CW-1:0] low_cnt_reg; // low time so far
  reg prev_reg; // last strobe level
  // glitches shorter than the minimum are dropped
  always @(posedge mclk) begin
    if (reset) begin
      low_cnt_reg <= {CW{1'b0}};
      prev_reg <= 1'b1;
      pulse_ok <= 1'b0;
    end else begin
      prev_reg <= strobe;
      pulse_ok <= strobe && !prev_reg && (low_cnt_reg >= MIN_CYC[CW-1:0]);
      if (strobe) begin
        low_cnt_reg <= {CW{1'b0}};
      end else if (low_cnt_reg != {CW{1'b1}}) begin
        low_cnt_reg <= low_cnt_reg + 1'b1;
      end
    end
  end
endmodule // epv_strobe_meter
`default_nettype wire

// ==== verification/epv_port_monitor.sv ====
// Purpose: port checks on the program/verify port
// Assumes: pin levels reach port0 through 2 sync flops and 2 more registers
// Notes: $past depth 6 sits inside the settle window
`default_nettype none
module epv_port_monitor #(
  parameter [7:0] SIG_BYTE0 = 8'hA5, // arbitrary value
  parameter [7:0] SIG_BYTE1 = 8'h5A // arbitrary value
) (
  input wire logic mclk, // clock
  input wire logic reset, // sync reset
  input wire logic reset_pin, // device reset pin
  input wire logic program_store_enable_n, // mode pin
  input wire logic latch_program_strobe, // strobe
  input wire logic external_access_prog_supply, // ea level
  input wire logic prog_supply_ok, // supply present
  input wire logic [7:0] port1_in, // address low
  input wire logic [7:0] port2_in, // address high, mode
  input wire logic [7:0] port3_in, // mode
  input wire logic [7:0] port0_out, // verify byte
  input wire logic port0_oe, // port 0 driven
  input wire logic [3:0] bus_addr, // register address
  input wire logic bus_rd, // read strobe
  input wire logic [7:0] bus_rdata // read data
);
  timeunit 1ns;
  timeprecision 100ps;
  // ************************************
  // assertions
  // ************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  chk_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
    else $error("read data not zero outside read slot");
  chk_unmapped_zero: assert property (bus_rd && bus_addr > 4'h2 |=> bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_ctrl_zero: assert property (bus_rd && bus_addr == 4'h0 |=> bus_rdata == 8'h00)
    else $error("control read not zero");
  // driving needs the verify levels seen some cycles before
  chk_oe_levels: assert property (port0_oe |-> $past(reset_pin, 6) && !$past(program_store_enable_n, 6)
    && $past(latch_program_strobe, 6))
    else $error("port 0 driven without verify levels");
  chk_oe_supply: assert property (port0_oe |-> !$past(prog_supply_ok, 6)
    && $past(external_access_prog_supply, 6))
    else $error("port 0 driven with supply applied");
  chk_oe_mode: assert property (port0_oe |-> $past(port2_in[7:6], 6) == 2'h0
    && $past(port3_in[7], 6) == $past(port3_in[6], 6))
    else $error("port 0 driven in unlisted mode");
  chk_sig_first: assert property (port0_oe && $past(port3_in[7:6], 6) == 2'h0
    && $past({port2_in[4:0], port1_in}, 6) == 13'h0030 |-> port0_out == SIG_BYTE0)
    else $error("first signature byte wrong");
  chk_sig_second: assert property (port0_oe && $past(port3_in[7:6], 6) == 2'h0
    && $past({port2_in[4:0], port1_in}, 6) == 13'h0031 |-> port0_out == SIG_BYTE1)
    else $error("second signature byte wrong");
  // a driven byte never changes under a standing enable
  chk_out_stands: assert property (port0_oe && $past(port0_oe) |-> $stable(port0_out))
    else $error("port 0 changed while driven");
  cover property ($rose(port0_oe));
  cover property (bus_rd && bus_addr == 4'h1);
  cover property (port0_oe && $past(port3_in[7:6], 6) == 2'h0);
endmodule // epv_port_monitor
bind epv_port epv_port_monitor #(.SIG_BYTE0(SIG_BYTE0), .SIG_BYTE1(SIG_BYTE1)) u_mon (.mclk(mclk),
  .reset(reset), .reset_pin(reset_pin), .program_store_enable_n(program_store_enable_n),
  .latch_program_strobe(latch_program_strobe), .external_access_prog_supply(external_access_prog_supply),
  .prog_supply_ok(prog_supply_ok), .port1_in(port1_in), .port2_in(port2_in), .port3_in(port3_in),
  .port0_out(port0_out), .port0_oe(port0_oe), .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));
`default_nettype wire

// ==== verification/epv_prog_model.sv ====
// Purpose: model of the external programming system
// Assumes: times scaled to PULSE_MIN_CYC of 20
// Notes: port 0 carries pull-ups when nobody drives it
`default_nettype none
module epv_prog_model (
  input wire logic mclk, // clock
  input wire logic [7:0] port0_out, // device byte
  input wire logic port0_oe, // device drives
  output logic reset_pin, // device reset pin
  output logic program_store_enable_n, // mode pin
  output logic latch_program_strobe, // strobe
  output logic external_access_prog_supply, // ea level
  output logic prog_supply_ok, // supply present
  output logic [7:0] port1_in, // address low
  output logic [7:0] port2_in, // address high, mode
  output logic [7:0] port3_in, // mode
  output wire logic [7:0] port0_in // resolved port 0
);
  timeunit 1ns;
  timeprecision 100ps;
  logic drive_reg; // programmer drives port 0
  logic [7:0] data_reg; // byte to program
  // pull-ups win only when both sides let go
  assign port0_in = drive_reg ? data_reg : (port0_oe ? port0_out : 8'hFF);
  initial begin
    {reset_pin, program_store_enable_n, latch_program_strobe, external_access_prog_supply} = 4'hF;
    {prog_supply_ok, drive_reg, data_reg} = 10'h000;
    {port1_in, port2_in, port3_in} = 24'h000000;
  end
  // ************************************
  // access sequences
  // ************************************
  task set_lv(input [1:0] p2m, input [1:0] p3m, input [12:0] a, input pgm);
    @(posedge mclk);
    port1_in <= a[7:0];
    port2_in <= {p2m, 1'b0, a[12:8]};
    port3_in <= {p3m, 6'h00};
    program_store_enable_n <= 1'b0;
    prog_supply_ok <= pgm;
  endtask
  task do_program(input [1:0] p2m, input [1:0] p3m, input [12:0] a, input [7:0] d);
    set_lv(p2m, p3m, a, 1'b1);
    drive_reg <= 1'b1;
    data_reg <= d;
    repeat (12) @(posedge mclk);
    repeat (15) begin
      latch_program_strobe <= 1'b0;
      repeat (24) @(posedge mclk);
      latch_program_strobe <= 1'b1;
      repeat (6) @(posedge mclk);
    end
    repeat (12) @(posedge mclk);
    program_store_enable_n <= 1'b1;
    prog_supply_ok <= 1'b0;
    drive_reg <= 1'b0;
  endtask
  task do_verify(input [1:0] p2m, input [1:0] p3m, input [12:0] a, output [7:0] v, output oe);
    set_lv(p2m, p3m, a, 1'b0);
    repeat (20) @(posedge mclk);
    #1;
    v = port0_in;
    oe = port0_oe;
    @(posedge mclk);
    program_store_enable_n <= 1'b1;
  endtask
endmodule // epv_prog_model
`default_nettype wire

// ==== verification/tb_eprom_program_verify_port.sv ====
// Purpose: testbench of the program/verify port
// Assumes: PULSE_MIN_CYC shortened to 20 cycles
// Notes: status compared on its low nibble only
`default_nettype none
module tb_eprom_program_verify_port;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, reset, bus_wr, bus_rd; // clock, reset, strobes
  logic [3:0] bus_addr; // register address
  logic [7:0] bus_wdata, d; // write data, scratch
  wire logic [7:0] bus_rdata, port0_out, p1, p2, p3, p0; // design outputs, pins
  wire logic port0_oe, rp, pe, st, xa, ps; // pin levels
  integer fail_count, n_checks;
  epv_port #(.PULSE_MIN_CYC(20)) dut (.mclk(mclk), .reset(reset), .reset_pin(rp), .program_store_enable_n(pe),
    .latch_program_strobe(st), .external_access_prog_supply(xa), .prog_supply_ok(ps), .port1_in(p1),
    .port2_in(p2), .port3_in(p3), .port0_in(p0), .port0_out(port0_out), .port0_oe(port0_oe),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));
  epv_prog_model prog (.mclk(mclk), .port0_out(port0_out), .port0_oe(port0_oe), .reset_pin(rp),
    .program_store_enable_n(pe), .latch_program_strobe(st), .external_access_prog_supply(xa),
    .prog_supply_ok(ps), .port1_in(p1), .port2_in(p2), .port3_in(p3), .port0_in(p0));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk; // scaled oscillator timing rides on mclk
  end
  // ************************************
  // tasks
  // ************************************
  task test_done;
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task check8(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask
  task bus_write(input [3:0] a, input [7:0] w);
    @(posedge mclk);
    {bus_addr, bus_wdata, bus_wr} <= {a, w, 1'b1};
    @(posedge mclk);
    bus_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task bus_read(input [3:0] a, output [7:0] r);
    @(posedge mclk);
    {bus_addr, bus_rd} <= {a, 1'b1};
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1 r = bus_rdata;
  endtask
  task wait_idle;
    integer i;
    i = 0;
    d = 8'hFF;
    while (d[3] !== 1'b0 && i < 12000) begin
      bus_read(4'h1, d);
      i++;
    end
    if (i == 12000) check8("busy", 8'h00, 8'hFF);
  endtask
  task stat(input [7:0] e);
    bus_read(4'h1, d);
    check8("status", e, d & 8'h0F);
  endtask
  task vfy(input [1:0] p2m, input [1:0] p3m, input [12:0] a, input [7:0] e, input eoe);
    logic [7:0] v;
    logic oe;
    prog.do_verify(p2m, p3m, a, v, oe);
    check8("port0", e, v);
    check8("port0_oe", {7'h00, eoe}, {7'h00, oe});
  endtask
  // ************************************
  // sequence
  // ************************************
  initial begin
    {fail_count, n_checks} = 0;
    {reset, bus_wr, bus_rd, bus_addr, bus_wdata} = 15'h4000;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    wait_idle;
    stat(8'h00);
    vfy(2'h0, 2'h3, 13'h0100, 8'hFF, 1'b1);
    vfy(2'h0, 2'h0, 13'h0030, 8'hA5, 1'b1);
    vfy(2'h0, 2'h0, 13'h0031, 8'h5A, 1'b1);
    prog.do_program(2'h2, 2'h3, 13'h0100, 8'h3C);
    vfy(2'h0, 2'h3, 13'h0100, 8'h3C, 1'b1);
    bus_read(4'h2, d);
    check8("pulse_count", 8'h0F, d);
    prog.do_program(2'h2, 2'h3, 13'h0100, 8'hF0);
    vfy(2'h0, 2'h3, 13'h0100, 8'h30, 1'b1);
    vfy(2'h1, 2'h3, 13'h0100, 8'hFF, 1'b0);
    prog.do_program(2'h2, 2'h2, 13'h0005, 8'h0F);
    stat(8'h04);
    vfy(2'h0, 2'h3, 13'h0105, 8'h0F, 1'b1);
    prog.do_program(2'h2, 2'h2, 13'h0025, 8'h00);
    vfy(2'h0, 2'h3, 13'h0105, 8'h0F, 1'b1);
    prog.do_program(2'h3, 2'h3, 13'h0000, 8'h00);
    stat(8'h05);
    prog.do_program(2'h2, 2'h3, 13'h0100, 8'h00);
    vfy(2'h0, 2'h3, 13'h0100, 8'h30, 1'b1);
    prog.do_program(2'h2, 2'h2, 13'h0005, 8'h00);
    vfy(2'h0, 2'h3, 13'h0105, 8'h0F, 1'b1);
    prog.do_program(2'h3, 2'h0, 13'h0000, 8'h00);
    stat(8'h07);
    vfy(2'h0, 2'h3, 13'h0100, 8'hFF, 1'b0);
    bus_read(4'hF, d);
    check8("unmapped", 8'h00, d);
    bus_write(4'h0, 8'h01);
    wait_idle;
    stat(8'h00);
    vfy(2'h0, 2'h3, 13'h0100, 8'hFF, 1'b1);
    test_done;
  end
  // two erase walks and eight program sequences take about 20500 cycles
  initial begin
    #200000;
    fail_count++;
    test_done;
  end
endmodule // tb_eprom_program_verify_port
`default_nettype wire
